// ===== hw/floppy_pkg.sv
// shared constants and types of the floppy command port and its host
package floppy_pkg;
   localparam logic [7:0] ADDR_COMMAND    = 8'hF8;
   localparam logic [7:0] ADDR_SECTOR     = 8'hFA;
   localparam logic [7:0] ADDR_DATA       = 8'hFB;
   localparam logic [7:0] ADDR_WAIT       = 8'hFC;
   localparam logic [7:0] CMD_SEEK        = 8'h13;
   localparam logic [7:0] CMD_STEP_IN     = 8'h43;
   localparam logic [7:0] CMD_STEP_OUT    = 8'h63;
   localparam logic [7:0] CMD_READ        = 8'h8C;
   localparam logic [2:0] READ_GROUP      = 3'h4;
   localparam int         READ_MULTI_BIT  = 4;
   localparam logic [3:0] GROUP_RESTORE   = 4'h0;
   localparam logic [3:0] GROUP_SEEK      = 4'h1;
   localparam logic [2:0] GROUP_STEP_IN   = 3'h2;
   localparam logic [2:0] GROUP_STEP_OUT  = 3'h3;
   localparam logic [6:0] TRACK_LAST      = 7'h4C;
   localparam logic [7:0] SECTOR_BYTES    = 8'h80;
   localparam int         STAT_NOT_READY  = 7;
   localparam int         STAT_SEEK_ERROR = 4;
   localparam int         STAT_TRACK_ZERO = 2;
   localparam int         WAIT_BYTE_BIT   = 7;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [7:0] OPEN_BUS        = 8'hFF;
   localparam int         STEP_GAP_CYCLES = 16;
   localparam logic [1:0] HEAD_HOLD_REVS  = 2'h2;

   typedef enum logic [2:0] {
      OP_NONE, OP_RESTORE, OP_SEEK, OP_STEP_IN, OP_STEP_OUT, OP_READ
   } op_t;

   function automatic op_t decode_cmd(input logic [7:0] code);
      op_t op;
      op = OP_NONE;
      if (code[7:4] == GROUP_RESTORE) begin
         op = OP_RESTORE;
      end else if (code[7:4] == GROUP_SEEK) begin
         op = OP_SEEK;
      end else if (code[7:5] == GROUP_STEP_IN) begin
         op = OP_STEP_IN;
      end else if (code[7:5] == GROUP_STEP_OUT) begin
         op = OP_STEP_OUT;
      end else if (code[7:5] == READ_GROUP && !code[READ_MULTI_BIT]) begin
         op = OP_READ;
      end
      return op;
   endfunction
endpackage

// ===== hw/floppy_bus_if.sv
// i/o bus between host processor and floppy controller
`timescale 1ns/10ps
interface floppy_bus_if;
   logic [7:0] io_addr;
   logic       io_wr;
   logic       io_rd;
   logic [7:0] io_wdata;
   logic [7:0] io_rdata;
   logic       io_wait;

   modport device (
      input  io_addr, io_wr, io_rd, io_wdata,
      output io_rdata, io_wait
   );
   modport host (
      output io_addr, io_wr, io_rd, io_wdata,
      input  io_rdata, io_wait
   );
endinterface

// ===== hw/floppy_controller.sv
// floppy controller end: command port, head stepping, sector read path
// What this block does
// (R1) reset steps head out to track zero
// (R2) step-in command moves one track inward, none at track 76
// (R3) step-out command moves one track outward
// (R4) seek: data port track, then command
// (R5) positioning commands ignore drive ready
// (R6) sector reads only while ready is low
// (R7) drive asserts ready only when spinning, loaded
// (R8) read command energizes head load at start
// (R9) head unloads after two idle revolutions
// (R10) sector read delivers 128 bytes per request
// (R11) wait port stalls until byte or completion
// (R12) status at command address, errors nonzero
// (R13) tracks numbered 0 outer to 76 inner
// (R14) host writes sector number before reading
// (R15) wait value msb: 1 byte, 0 completion
// (R16) read encoding 100, single, format, load
// (R17) data read pops byte, clears request once the buffer is empty
// (R18) completion raised at end, cleared by status
`timescale 1ns/10ps
module floppy_controller
   import floppy_pkg::*;
#(
   parameter int         STEP_GAP   = STEP_GAP_CYCLES,
   parameter logic [6:0] LAST_TRACK = TRACK_LAST
) (
   input  wire logic     clk,           // 25 MHz bus clock
   input  wire logic     sys_rst,       // synchronous reset, starts restore
   floppy_bus_if.device  bus,           // host i/o ports
   input  wire logic     ready_n,       // drive ready, low active
   input  wire logic     track_zero_n,  // head at track 0, low active
   input  wire logic     index_pulse,   // one pulse per revolution
   output logic          step_pulse,    // one-cycle step strobe
   output logic          step_dir_in,   // 1 steps toward inner tracks
   output logic          head_load,     // head-load solenoid
   input  wire logic     disk_valid,    // disk byte offered
   input  wire logic [7:0] disk_data,   // disk byte
   output logic          disk_ready,    // buffer takes disk byte
   output logic          busy           // command in progress
);
   typedef enum logic [1:0] {S_IDLE, S_STEP, S_SETTLE, S_READ} ctl_state_t;

   ctl_state_t  state;
   logic [6:0]  cur_track;
   logic [6:0]  target;
   logic        restoring;
   logic [7:0]  track_reg;
   logic [7:0]  sector_reg;
   logic [7:0]  status;
   logic        finish;
   logic        completion_request;
   logic [15:0] gap_cnt;
   logic [7:0]  bytes_in;
   logic [7:0]  bytes_out;
   logic [1:0]  idx_count;
   logic [7:0]  buf_mem [2];
   logic        buf_wr;
   logic        buf_rd;
   logic [1:0]  buf_count;
   logic        byte_request;
   logic        rd_taken;
   logic        pop;
   logic        push;
   logic        status_rd;
   logic        cmd_wr;
   logic        start_read;
   op_t         op;

   assign op           = decode_cmd(bus.io_wdata);
   assign byte_request = (state == S_READ) && (buf_count != 2'h0);
   // the wait port is the only address that ever stalls the bus
   assign bus.io_wait  = bus.io_rd && (bus.io_addr == ADDR_WAIT) &&
                         !byte_request && !completion_request;    // see (R11)
   assign rd_taken     = bus.io_rd && !bus.io_wait;
   assign pop          = rd_taken && (bus.io_addr == ADDR_DATA) && byte_request; // see (R17)
   assign status_rd    = rd_taken && (bus.io_addr == ADDR_COMMAND);
   assign cmd_wr       = bus.io_wr && (bus.io_addr == ADDR_COMMAND) && (state == S_IDLE);
   assign start_read   = cmd_wr && (op == OP_READ) && !ready_n;  // see (R6) (R16)
   assign disk_ready   = (state == S_READ) && (buf_count != 2'h2) &&
                         (bytes_in != SECTOR_BYTES);
   assign push         = disk_valid && disk_ready;
   assign step_pulse   = (state == S_STEP);
   assign busy         = (state != S_IDLE);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bus.io_rdata <= 8'h00;
      end else if (rd_taken) begin
         unique case (bus.io_addr)
            ADDR_COMMAND: bus.io_rdata <= status;                        // see (R12)
            ADDR_SECTOR:  bus.io_rdata <= sector_reg;
            ADDR_DATA:    bus.io_rdata <= byte_request ? buf_mem[buf_rd] : track_reg;
            ADDR_WAIT:    bus.io_rdata <= {byte_request, 7'h00};         // see (R15)
            default:      bus.io_rdata <= OPEN_BUS;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         track_reg  <= 8'h00;
         sector_reg <= 8'h00;
      end else if (bus.io_wr) begin
         if (bus.io_addr == ADDR_DATA) begin
            track_reg <= bus.io_wdata;                                   // see (R4)
         end
         if (bus.io_addr == ADDR_SECTOR) begin
            sector_reg <= bus.io_wdata;                                  // see (R14)
         end
      end
   end

   // two-entry buffer: a slow host stalls the disk side, not drops bytes
   always_ff @(posedge clk) begin
      if (sys_rst || start_read) begin
         buf_wr    <= 1'b0;
         buf_rd    <= 1'b0;
         buf_count <= 2'h0;
      end else begin
         if (push) begin
            buf_mem[buf_wr] <= disk_data;
            buf_wr          <= !buf_wr;
         end
         if (pop) begin
            buf_rd <= !buf_rd;
         end
         buf_count <= buf_count + 2'(push) - 2'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || start_read) begin
         bytes_in  <= 8'h00;
         bytes_out <= 8'h00;
      end else begin
         if (push) begin
            bytes_in <= bytes_in + 8'h01;
         end
         if (pop) begin
            bytes_out <= bytes_out + 8'h01;                              // see (R10)
         end
      end
   end

   always_ff @(posedge clk) begin
      finish <= 1'b0;
      if (sys_rst) begin
         state       <= S_SETTLE;                                        // see (R1)
         restoring   <= 1'b1;
         cur_track   <= 7'h00;
         target      <= 7'h00;
         step_dir_in <= 1'b0;
         gap_cnt     <= 16'h0000;
         status      <= STATUS_RESET;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (cmd_wr) begin
                  gap_cnt   <= 16'h0000;
                  restoring <= 1'b0;
                  status    <= STATUS_RESET;
                  // positioning never looks at ready_n
                  unique case (op)                                       // see (R5)
                     OP_RESTORE: begin
                        restoring <= 1'b1;
                        state     <= S_SETTLE;
                     end
                     OP_SEEK: begin
                        if (track_reg > {1'b0, LAST_TRACK}) begin        // see (R13)
                           status[STAT_SEEK_ERROR] <= 1'b1;
                           finish                  <= 1'b1;
                        end else begin
                           target <= track_reg[6:0];
                           state  <= S_SETTLE;
                        end
                     end
                     OP_STEP_IN: begin
                        target <= (cur_track == LAST_TRACK) ? cur_track
                                                           : cur_track + 7'h01; // see (R2)
                        state  <= S_SETTLE;
                     end
                     OP_STEP_OUT: begin
                        target <= (cur_track == 7'h00) ? 7'h00 : cur_track - 7'h01; // see (R3)
                        state  <= S_SETTLE;
                     end
                     OP_READ: begin
                        if (ready_n) begin
                           status[STAT_NOT_READY] <= 1'b1;               // see (R6)
                           finish                 <= 1'b1;
                        end else begin
                           state <= S_READ;
                        end
                     end
                     OP_NONE: begin
                        finish <= 1'b1;
                     end
                  endcase
               end
            end
            S_STEP: begin
               gap_cnt <= 16'h0000;
               state   <= S_SETTLE;
               if (step_dir_in) begin
                  cur_track <= cur_track + 7'h01;
               end else if (cur_track != 7'h00) begin
                  cur_track <= cur_track - 7'h01;
               end
            end
            S_SETTLE: begin
               if (gap_cnt < 16'(STEP_GAP)) begin
                  gap_cnt <= gap_cnt + 16'h0001;
               end else if (restoring) begin
                  if (!track_zero_n) begin                               // see (R1)
                     cur_track                <= 7'h00;
                     restoring                <= 1'b0;
                     status[STAT_TRACK_ZERO]  <= 1'b1;
                     finish                   <= 1'b1;
                     state                    <= S_IDLE;
                  end else begin
                     step_dir_in <= 1'b0;
                     state       <= S_STEP;
                  end
               end else if (cur_track == target) begin
                  status[STAT_TRACK_ZERO] <= !track_zero_n;
                  finish                  <= 1'b1;
                  state                   <= S_IDLE;
               end else begin
                  step_dir_in <= (target > cur_track);
                  state       <= S_STEP;
               end
            end
            S_READ: begin
               if (ready_n) begin
                  status[STAT_NOT_READY] <= 1'b1;
                  finish                 <= 1'b1;
                  state                  <= S_IDLE;
               end else if (pop && bytes_out == SECTOR_BYTES - 8'h01) begin
                  finish <= 1'b1;                                        // see (R10)
                  state  <= S_IDLE;
               end
            end
         endcase
      end
   end

   // set wins over the host's status read in the same cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         completion_request <= 1'b0;
      end else if (finish) begin
         completion_request <= 1'b1;                                     // see (R18)
      end else if (status_rd || cmd_wr) begin
         completion_request <= 1'b0;
      end
   end

   // revolutions counted by index pulses once the read is over
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         head_load <= 1'b0;
         idx_count <= 2'h0;
      end else if (start_read) begin
         head_load <= 1'b1;                                              // see (R8)
         idx_count <= 2'h0;
      end else if (head_load && state != S_READ && index_pulse) begin
         idx_count <= idx_count + 2'h1;
         if (idx_count == HEAD_HOLD_REVS - 2'h1) begin
            head_load <= 1'b0;                                           // see (R9)
         end
      end
   end
endmodule

// ===== hw/floppy_host.sv
// host end: issues commands over the i/o ports and drains sector bytes
`timescale 1ns/10ps
module floppy_host
   import floppy_pkg::*;
(
   input  wire logic       clk,         // 25 MHz bus clock
   input  wire logic       sys_rst,     // synchronous reset
   floppy_bus_if.host      bus,         // controller i/o ports
   input  wire logic       cmd_valid,   // command offered
   output logic            cmd_ready,   // command taken
   input  wire logic [7:0] cmd_code,    // command byte
   input  wire logic [7:0] cmd_track,   // seek target
   input  wire logic [7:0] cmd_sector,  // sector number
   output logic            byte_valid,  // sector byte held
   output logic [7:0]      byte_data,   // sector byte
   input  wire logic       byte_ready,  // user takes byte
   output logic            done,        // one-cycle completion pulse
   output logic [7:0]      done_status  // status word of that command
);
   typedef enum logic [3:0] {
      H_IDLE, H_SECTOR_NUMBER, H_TRK, H_CMD, H_POLL, H_POLL_CHK,
      H_DATA, H_DATA_CHK, H_HOLD, H_STAT, H_STAT_CHK
   } host_state_t;

   host_state_t state;
   logic [7:0]  code_q;
   logic [7:0]  track_q;
   logic [7:0]  sector_q;

   assign cmd_ready  = (state == H_IDLE);
   assign byte_valid = (state == H_HOLD);
   assign bus.io_rd  = (state == H_POLL) || (state == H_DATA) || (state == H_STAT);
   assign bus.io_wr  = (state == H_SECTOR_NUMBER) || (state == H_TRK) || (state == H_CMD);

   always_comb begin
      bus.io_addr  = ADDR_WAIT;
      bus.io_wdata = 8'h00;
      unique case (state)
         H_SECTOR_NUMBER: begin
            bus.io_addr  = ADDR_SECTOR;
            bus.io_wdata = sector_q;                                     // see (R14)
         end
         H_TRK: begin
            bus.io_addr  = ADDR_DATA;
            bus.io_wdata = track_q;                                      // see (R4)
         end
         H_CMD: begin
            bus.io_addr  = ADDR_COMMAND;
            bus.io_wdata = code_q;
         end
         H_DATA:  bus.io_addr = ADDR_DATA;
         H_STAT:  bus.io_addr = ADDR_COMMAND;
         default: bus.io_addr = ADDR_WAIT;
      endcase
   end

   // after reset the controller restores, so the host waits for it first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state    <= H_POLL;
         code_q   <= 8'h00;
         track_q  <= 8'h00;
         sector_q <= 8'h00;
      end else begin
         unique case (state)
            H_IDLE: begin
               if (cmd_valid) begin
                  code_q   <= cmd_code;
                  track_q  <= cmd_track;
                  sector_q <= cmd_sector;
                  state    <= H_SECTOR_NUMBER;
               end
            end
            H_SECTOR_NUMBER: state <= H_TRK;
            H_TRK:  state <= H_CMD;
            H_CMD:  state <= H_POLL;
            H_POLL: begin
               if (!bus.io_wait) begin                                   // see (R11)
                  state <= H_POLL_CHK;
               end
            end
            H_POLL_CHK: state <= bus.io_rdata[WAIT_BYTE_BIT] ? H_DATA : H_STAT; // see (R15)
            H_DATA:     state <= H_DATA_CHK;
            H_DATA_CHK: state <= H_HOLD;
            H_HOLD: begin
               if (byte_ready) begin
                  state <= H_POLL;
               end
            end
            H_STAT:     state <= H_STAT_CHK;                             // see (R12)
            H_STAT_CHK: state <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         byte_data   <= 8'h00;
         done        <= 1'b0;
         done_status <= 8'h00;
      end else begin
         done <= (state == H_STAT_CHK);
         if (state == H_DATA_CHK) begin
            byte_data <= bus.io_rdata;
         end
         if (state == H_STAT_CHK) begin
            done_status <= bus.io_rdata;
         end
      end
   end
endmodule

// ===== sim/floppy_bus_asserts.sv
// bus-level checks between host end and controller end
`timescale 1ns/10ps
module floppy_bus_asserts
   import floppy_pkg::*;
(
   input wire logic       clk,      // bus clock
   input wire logic       sys_rst,  // synchronous reset
   input wire logic [7:0] io_addr,  // port address
   input wire logic       io_wr,    // write strobe
   input wire logic       io_rd,    // read request
   input wire logic [7:0] io_wdata, // write data
   input wire logic [7:0] io_rdata, // read data
   input wire logic       io_wait   // stall
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   logic rd_fc;
   assign rd_fc = io_rd && !io_wait && io_addr == ADDR_WAIT;

   a_wait_only_fc: assert property (io_wait |-> io_rd && io_addr == ADDR_WAIT)
      else $error("stall outside wait port read");
   a_wait_bounded: assert property ($rose(io_wait) |-> ##[1:1000] !io_wait)
      else $error("stall never ended");
   a_rd_held: assert property (io_rd && io_wait |=> io_rd && $stable(io_addr))
      else $error("read dropped while stalled");
   a_wait_value: assert property (rd_fc |=> io_rdata == 8'h80 || io_rdata == 8'h00)
      else $error("wait port value malformed");
   a_seek_order: assert property (
      io_wr && io_addr == ADDR_COMMAND && io_wdata == CMD_SEEK
      |-> $past(io_wr) && $past(io_addr) == ADDR_DATA)
      else $error("seek without target first");
   a_sector_first: assert property (
      io_wr && io_addr == ADDR_COMMAND && io_wdata == CMD_READ
      |-> $past(io_wr, 2) && $past(io_addr, 2) == ADDR_SECTOR)
      else $error("read without sector first");
   a_status_after_end: assert property (
      rd_fc ##1 !io_rdata[WAIT_BYTE_BIT]
      |-> ##[0:4] (io_rd && io_addr == ADDR_COMMAND))
      else $error("status not read after completion");
   a_data_after_byte: assert property (
      rd_fc ##1 io_rdata[WAIT_BYTE_BIT]
      |-> ##[0:4] (io_rd && io_addr == ADDR_DATA))
      else $error("data port not read after byte request");
endmodule

// ===== sim/tb_floppy_command_port.sv
// top bench: host and controller joined, drive and user side modelled here
`timescale 1ns/10ps
module tb_floppy_command_port
   import floppy_pkg::*;
;
   localparam int         REV         = 64;
   localparam logic [7:0] SEEK_TO [4] = '{8'h05, 8'h4C, 8'h4D, 8'h00};
   localparam logic [7:0] SEEK_ST [4] = '{8'h00, 8'h00, 8'h10, 8'h04};
   localparam logic [7:0] SEEK_AT [4] = '{8'h05, 8'h4C, 8'h4C, 8'h00};

   logic       clk         = 1'b0;
   logic       sys_rst     = 1'b1;
   logic       ready_n     = 1'b1;
   logic       index_pulse = 1'b0;
   logic       disk_valid  = 1'b0;
   logic [7:0] disk_data   = 8'hE5;
   logic       cmd_valid   = 1'b0;
   logic       byte_ready  = 1'b0;
   logic [7:0] cmd_code    = 8'h00;
   logic [7:0] cmd_track   = 8'h00;
   logic [7:0] cmd_sector  = 8'h01;
   wire        track_zero_n, step_pulse, step_dir_in, head_load, disk_ready;
   wire        cmd_ready, byte_valid, done, busy;
   wire  [7:0] byte_data, done_status;
   int         head_track  = 5;
   int         rev_cnt     = 0;
   int         stall       = 0;
   int         n_bytes     = 0;
   int         n_fail      = 0;
   int         checks_done = 0;
   bit         seen_full   = 1'b0;

   initial begin
      forever #20 clk = ~clk;
   end

   floppy_bus_if u_floppy_bus_if ();

   floppy_controller #(.STEP_GAP(2), .LAST_TRACK(TRACK_LAST)) u_floppy_controller (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .bus          (u_floppy_bus_if.device),
      .ready_n      (ready_n),
      .track_zero_n (track_zero_n),
      .index_pulse  (index_pulse),
      .step_pulse   (step_pulse),
      .step_dir_in  (step_dir_in),
      .head_load    (head_load),
      .disk_valid   (disk_valid),
      .disk_data    (disk_data),
      .disk_ready   (disk_ready),
      .busy         (busy)
   );

   floppy_host u_floppy_host (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .bus         (u_floppy_bus_if.host),
      .cmd_valid   (cmd_valid),
      .cmd_ready   (cmd_ready),
      .cmd_code    (cmd_code),
      .cmd_track   (cmd_track),
      .cmd_sector  (cmd_sector),
      .byte_valid  (byte_valid),
      .byte_data   (byte_data),
      .byte_ready  (byte_ready),
      .done        (done),
      .done_status (done_status)
   );

   floppy_bus_asserts u_floppy_bus_asserts (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .io_addr  (u_floppy_bus_if.io_addr),
      .io_wr    (u_floppy_bus_if.io_wr),
      .io_rd    (u_floppy_bus_if.io_rd),
      .io_wdata (u_floppy_bus_if.io_wdata),
      .io_rdata (u_floppy_bus_if.io_rdata),
      .io_wait  (u_floppy_bus_if.io_wait)
   );

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // drive model: head moves unclamped so a step past either end shows up
   assign track_zero_n = (head_track != 0);
   always @(posedge clk) begin
      if (step_pulse) begin
         head_track <= step_dir_in ? head_track + 1 : head_track - 1;
      end
      rev_cnt <= (rev_cnt == REV - 1) ? 0 : rev_cnt + 1;
      index_pulse <= (rev_cnt == REV - 1);
      // user takes one byte in three so the buffer fills
      stall <= (stall == 2) ? 0 : stall + 1;
      byte_ready <= (stall == 2);
      // early in the sector, so the 128-byte limit cannot be what refused it
      if (disk_valid && !disk_ready && busy && n_bytes < 64) begin
         seen_full <= 1'b1;
      end
      if (byte_valid && byte_ready) begin
         n_bytes <= n_bytes + 1;
         chk8("sector byte", 8'hE5, byte_data);
      end
   end

   task automatic wait_done(output logic [7:0] st);
      int i;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (done !== 1'b1 && i < 20000);
      st = done_status;
      if (done !== 1'b1) begin
         n_fail++;
         $display("mismatch done expected 1 seen timeout");
         report_and_stop();
      end
   endtask

   task automatic run_cmd(input logic [7:0] code, input logic [7:0] trk,
                          output logic [7:0] st);
      int i;
      @(posedge clk);
      cmd_code  <= code;
      cmd_track <= trk;
      cmd_valid <= 1'b1;
      i = 0;
      do begin
         @(negedge clk);
         i++;
      end while (cmd_ready !== 1'b1 && i < 100);
      if (cmd_ready !== 1'b1) begin
         n_fail++;
         $display("mismatch cmd_ready expected 1 seen timeout");
         report_and_stop();
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      wait_done(st);
   endtask

   initial begin
      logic [7:0] st;
      int         k;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      wait_done(st);
      chk8("restore status", 8'h04, st);
      chk8("restore track", 8'h00, 8'(head_track));
      chk8("busy after restore", 8'h00, {7'h00, busy});
      $display("test restore done");
      // drive not ready: positioning must still work
      for (k = 1; k <= 3; k++) begin
         run_cmd(CMD_STEP_IN, 8'h00, st);
         chk8("step in track", 8'(k), 8'(head_track));
         chk8("step in status", 8'h00, st);
      end
      run_cmd(CMD_STEP_OUT, 8'h00, st);
      chk8("step out track", 8'h02, 8'(head_track));
      $display("test step done");
      for (k = 0; k < 4; k++) begin
         run_cmd(CMD_SEEK, SEEK_TO[k], st);
         chk8("seek status", SEEK_ST[k], st);
         chk8("seek track", SEEK_AT[k], 8'(head_track));
         if (k == 1) begin
            run_cmd(CMD_STEP_IN, 8'h00, st);
            chk8("step at inner track", 8'h4C, 8'(head_track));
         end
      end
      $display("test seek done");
      // host-issued restore from one track in
      run_cmd(CMD_STEP_IN, 8'h00, st);
      run_cmd({GROUP_RESTORE, 4'h0}, 8'h00, st);
      chk8("restore cmd status", 8'h04, st);
      chk8("restore cmd track", 8'h00, 8'(head_track));
      // sector write is not built here, yet it must still complete
      run_cmd(8'hAC, 8'h00, st);
      chk8("unbuilt cmd status", 8'h00, st);
      $display("test command decode done");
      run_cmd(CMD_READ, 8'h00, st);
      chk8("refused read status", 8'h80, st);
      chk8("refused read bytes", 8'h00, 8'(n_bytes));
      chk8("refused read head", 8'h00, {7'h00, head_load});
      $display("test read refused done");
      @(posedge clk);
      ready_n    <= 1'b0;
      disk_valid <= 1'b1;
      run_cmd(CMD_READ, 8'h00, st);
      chk8("read status", 8'h00, st);
      chk8("read bytes", 8'h80, 8'(n_bytes));
      chk8("head load after read", 8'h01, {7'h00, head_load});
      chk8("buffer refused disk", 8'h01, {7'h00, seen_full});
      @(posedge clk);
      disk_valid <= 1'b0;
      repeat (2 * REV + 4) @(negedge clk);
      chk8("head load released", 8'h00, {7'h00, head_load});
      $display("test read done");
      report_and_stop();
   end
endmodule
